// [include/pcm_pkg.sv]
// package of constants and types for the port setup message handler
package pcm_pkg;

  // ----
  // structure
  // ----
  localparam int          NUM_PORTS = 2;
  localparam int          PORT_W    = 1;

  // ----
  // mode field codes
  // ----
  localparam logic [1:0]  MODE_KEEP   = 2'h0;
  localparam logic [1:0]  MODE_WRAP   = 2'h1;
  localparam logic [1:0]  MODE_NORMAL = 2'h2;
  localparam logic [1:0]  MODE_PRIV   = 2'h3;
  localparam logic [1:0]  MODE_RESET  = MODE_NORMAL;

  // ----
  // reply result codes
  // ----
  localparam logic [7:0]  RC_OK        = 8'h00;
  localparam logic [7:0]  RC_BAD_FIELD = 8'h01;

  // ----
  // alert codes: type, subtype, type info
  // ----
  localparam logic [23:0] ALERT_SLOW_SPEED = 24'h06_0500;
  localparam logic [23:0] ALERT_ALARM_THR  = 24'h1A_0000;

  // ----
  // timing
  // ----
  localparam int          CLK_MHZ          = 20;
  localparam int          ACK_LONG_MIN_US  = 100;
  localparam int          ACK_SHORT_MIN_US = 25;
  localparam int          ACK_W            = 13;
  localparam logic [ACK_W-1:0] ACK_LONG_CYC  = ACK_W'(ACK_LONG_MIN_US * CLK_MHZ);
  localparam logic [ACK_W-1:0] ACK_SHORT_CYC = ACK_W'(ACK_SHORT_MIN_US * CLK_MHZ);

  // ----
  // recovery count limit and reset values
  // ----
  localparam logic [15:0] ERP_CNT_MAX = 16'hFFFF;
  localparam logic [15:0] ZERO16      = 16'h0000;
  localparam logic [7:0]  ZERO8       = 8'h00;
  localparam logic [31:0] ZERO32      = 32'h0000_0000;

  // ----
  // states
  // ----
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_CHECK = 5'b00010,
    ST_FLUSH = 5'b00100,
    ST_REPLY = 5'b01000,
    ST_SLOW  = 5'b10000
  } pcm_state_e;

  // ----
  // carriers
  // ----
  typedef struct packed {
    logic [7:0]        port;
    logic [PORT_W-1:0] via_port;
    logic [15:0]       tag;
    logic [31:0]       reply_route;
    logic [7:0]        first_frame_allowance;
    logic [7:0]        rotation_frame_cap;
    logic              user_char_enable;
    logic              reflect;
    logic [1:0]        mode;
    logic              long_reach_enable;
    logic              short_ack_timeout;
    logic [15:0]       alarm_threshold;
    logic              offer_fast_rate;
    logic              offer_slow_rate;
  } pcm_setup_msg_s;

  typedef struct packed {
    logic [7:0]        first_frame_allowance;
    logic [7:0]        rotation_frame_cap;
    logic              user_char_enable;
    logic              long_reach_on;
    logic [ACK_W-1:0]  ack_tmo_cycles;
    logic              offer_fast_rate;
    logic              offer_slow_rate;
    logic              single_speed;
    logic [15:0]       alarm_threshold;
    logic [1:0]        mode;
  } pcm_port_cfg_s;

  typedef struct packed {
    logic              valid;
    logic [15:0]       tag;
    logic [31:0]       route;
    logic [PORT_W-1:0] out_port;
    logic [7:0]        code;
  } pcm_reply_s;

  typedef struct packed {
    logic              valid;
    logic [15:0]       tag;
    logic [31:0]       route;
    logic [PORT_W-1:0] out_port;
    logic [PORT_W-1:0] port;
    logic [23:0]       code;
  } pcm_alert_s;

endpackage

// [src/pcm_port_setup.sv]
// port setup message handler: decode, store, reply and alert
`timescale 1ns/100ps

// Function
// - every setup message gets a reply back to the master
// - keep tag and route; use them and arrival port for reply and alerts
// - store first frame allowance and per-rotation frame cap
// - cap below allowance: discard message, reply bad field
// - user character enable gates sending and forwarding user characters
// - dual-port node: reflect sets passthrough; clear only with both ports operational
// - mode field: keep, wrap, normal, privileged
// - keep mode with alerts pending: flush alerts before the reply
// - wrap only via another port, else bad field; wrap makes port non-operational
// - privileged via other port leaves wrap and starts beginning communication
// - normal request on a wrapped port: bad field, stay in wrap
// - long reach requested but unsupported: bad field
// - long reach sets 100 us timeout, else 25 us and option off
// - short ack timeout forces the 25 us timeout
// - alarm alert once when recovery count equals nonzero threshold
// - inquiry with clear request zeroes recovery count
// - rate offers: none keep, one rate means single speed, both both
// - only the latest setup message parameters are kept
// - after reply, dual-rate port running slow raises slow speed alert
// - alert tag stays in use until a later setup message changes it
module pcm_port_setup
  import pcm_pkg::*;
(
  input  wire logic                      sys_clk_in,
  input  wire logic                      rst_in,
  input  wire logic                      ce_in,
  input  wire logic                      msg_valid_in,
  input  wire pcm_setup_msg_s            msg_in,
  output      logic                      msg_ready_out,
  input  wire logic                      dual_port_node_in,
  input  wire logic [NUM_PORTS-1:0]      long_reach_cap_in,
  input  wire logic [NUM_PORTS-1:0]      dual_rate_cap_in,
  input  wire logic [NUM_PORTS-1:0]      running_slow_in,
  input  wire logic [NUM_PORTS-1:0]      alert_pending_in,
  input  wire logic [NUM_PORTS-1:0]      erp_invoked_in,
  input  wire logic [NUM_PORTS-1:0]      inquiry_clear_in,
  input  wire logic [NUM_PORTS-1:0]      port_ready_in,
  output      logic [NUM_PORTS-1:0]      flush_req_out,
  output      logic [NUM_PORTS-1:0]      port_operational_out,
  output      logic [NUM_PORTS-1:0]      begin_comm_out,
  output      logic                      passthrough_flag_out,
  output      pcm_port_cfg_s             port_cfg_out [NUM_PORTS],
  output      pcm_reply_s                reply_out,
  output      pcm_alert_s                alert_out
);

  // ----
  // helpers
  // ----
  function automatic logic port_hit(input logic [7:0] field, input int idx);
    port_hit = (field == 8'(idx));
  endfunction

  // ----
  // storage
  // ----
  pcm_state_e              state_q;
  pcm_setup_msg_s          msg_q;
  logic                    ok_q;
  logic [15:0]             tag_q      [NUM_PORTS];
  logic [31:0]             route_q    [NUM_PORTS];
  logic [PORT_W-1:0]       arrive_q   [NUM_PORTS];
  logic [15:0]             erp_cnt_q  [NUM_PORTS];
  logic [NUM_PORTS-1:0]    setup_seen_q;
  logic [NUM_PORTS-1:0]    alarm_pend_q;
  logic [NUM_PORTS-1:0]    slow_pend_q;
  logic [NUM_PORTS-1:0]    gnt_alarm;
  logic [NUM_PORTS-1:0]    gnt_slow;
  logic                    in_range;
  logic [PORT_W-1:0]       pidx;
  logic [1:0]              cur_mode;
  logic                    chk_ok;
  logic                    commit;

  assign in_range = (msg_q.port < 8'(NUM_PORTS));
  assign pidx     = msg_q.port[PORT_W-1:0];
  assign cur_mode = port_cfg_out[pidx].mode;

  // ----
  // field check
  // ----
  always_comb begin
    chk_ok = in_range;
    if (msg_q.rotation_frame_cap < msg_q.first_frame_allowance) begin
      chk_ok = 1'b0;
    end
    if (msg_q.mode == MODE_WRAP && port_hit(msg_q.port, int'(msg_q.via_port))) begin
      chk_ok = 1'b0;
    end
    if (msg_q.mode == MODE_NORMAL && cur_mode == MODE_WRAP) begin
      chk_ok = 1'b0;
    end
    if (msg_q.long_reach_enable && !long_reach_cap_in[pidx]) begin
      chk_ok = 1'b0;
    end
  end

  assign commit = (state_q == ST_CHECK) && chk_ok;

  // ----
  // sequencer
  // ----
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      state_q       <= ST_IDLE;
      msg_q         <= '0;
      ok_q          <= 1'b0;
      msg_ready_out <= 1'b0;
    end else if (ce_in) begin
      msg_ready_out <= 1'b0;
      case (state_q)
        ST_IDLE: begin
          msg_ready_out <= 1'b1;
          if (msg_valid_in && msg_ready_out) begin
            msg_q         <= msg_in;
            msg_ready_out <= 1'b0;
            state_q       <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          ok_q <= chk_ok;
          if (chk_ok && msg_q.mode == MODE_KEEP && alert_pending_in[pidx]) begin
            state_q <= ST_FLUSH;
          end else begin
            state_q <= ST_REPLY;
          end
        end
        ST_FLUSH: begin
          if (!alert_pending_in[pidx]) begin
            state_q <= ST_REPLY;
          end
        end
        ST_REPLY: begin
          state_q <= (ok_q && in_range) ? ST_SLOW : ST_IDLE;
        end
        ST_SLOW: begin
          state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----
  // flush request
  // ----
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      flush_req_out <= '0;
    end else if (ce_in) begin
      flush_req_out <= '0;
      if ((state_q == ST_FLUSH || (state_q == ST_CHECK && chk_ok && msg_q.mode == MODE_KEEP))
          && alert_pending_in[pidx]) begin
        flush_req_out[pidx] <= 1'b1;
      end
    end
  end

  // ----
  // reply
  // ----
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      reply_out <= '0;
    end else if (ce_in) begin
      reply_out.valid <= 1'b0;
      if (state_q == ST_REPLY) begin
        reply_out.valid    <= 1'b1;
        reply_out.tag      <= msg_q.tag;
        reply_out.route    <= msg_q.reply_route;
        reply_out.out_port <= msg_q.via_port;
        reply_out.code     <= ok_q ? RC_OK : RC_BAD_FIELD;
      end
    end
  end

  // ----
  // passthrough flag
  // ----
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      passthrough_flag_out <= 1'b0;
    end else if (ce_in) begin
      if (commit && dual_port_node_in) begin
        if (msg_q.reflect) begin
          passthrough_flag_out <= 1'b1;
        end else if (&port_operational_out) begin
          passthrough_flag_out <= 1'b0;
        end
      end
    end
  end

  // ----
  // alert arbitration, alarm alerts before slow speed alerts, lowest port first within each
  // ----
  always_comb begin
    logic found;
    found     = 1'b0;
    gnt_alarm = '0;
    gnt_slow  = '0;
    if (state_q == ST_IDLE) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (!found && setup_seen_q[p] && alarm_pend_q[p]) begin
          gnt_alarm[p] = 1'b1;
          found        = 1'b1;
        end
      end
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (!found && setup_seen_q[p] && slow_pend_q[p]) begin
          gnt_slow[p] = 1'b1;
          found       = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      alert_out <= '0;
    end else if (ce_in) begin
      alert_out.valid <= 1'b0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (gnt_alarm[p] || gnt_slow[p]) begin
          alert_out.valid    <= 1'b1;
          alert_out.tag      <= tag_q[p];
          alert_out.route    <= route_q[p];
          alert_out.out_port <= arrive_q[p];
          alert_out.port     <= PORT_W'(p);
          alert_out.code     <= gnt_alarm[p] ? ALERT_ALARM_THR : ALERT_SLOW_SPEED;
        end
      end
    end
  end

  // ----
  // per-port state
  // ----
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic sel;
    logic erp_hit;
    assign sel     = commit && port_hit(msg_q.port, p);
    assign erp_hit = erp_invoked_in[p] && !inquiry_clear_in[p] && erp_cnt_q[p] != ERP_CNT_MAX
                     && port_cfg_out[p].alarm_threshold != ZERO16
                     && (erp_cnt_q[p] + 16'h0001) == port_cfg_out[p].alarm_threshold;

    // operating parameters
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        port_cfg_out[p]                <= '0;
        port_cfg_out[p].ack_tmo_cycles <= ACK_SHORT_CYC;
        port_cfg_out[p].mode           <= MODE_RESET;
      end else if (ce_in && sel) begin
        port_cfg_out[p].first_frame_allowance <= msg_q.first_frame_allowance;
        port_cfg_out[p].rotation_frame_cap    <= msg_q.rotation_frame_cap;
        port_cfg_out[p].user_char_enable      <= msg_q.user_char_enable;
        port_cfg_out[p].long_reach_on         <= msg_q.long_reach_enable;
        port_cfg_out[p].alarm_threshold       <= msg_q.alarm_threshold;
        if (msg_q.long_reach_enable && !msg_q.short_ack_timeout) begin
          port_cfg_out[p].ack_tmo_cycles <= ACK_LONG_CYC;
        end else begin
          port_cfg_out[p].ack_tmo_cycles <= ACK_SHORT_CYC;
        end
        if (msg_q.offer_fast_rate || msg_q.offer_slow_rate) begin
          port_cfg_out[p].offer_fast_rate <= msg_q.offer_fast_rate;
          port_cfg_out[p].offer_slow_rate <= msg_q.offer_slow_rate;
          port_cfg_out[p].single_speed    <= msg_q.offer_fast_rate ^ msg_q.offer_slow_rate;
        end
        if (msg_q.mode != MODE_KEEP) begin
          port_cfg_out[p].mode <= msg_q.mode;
        end
      end
    end

    // reply route, tag and arrival port
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        tag_q[p]        <= ZERO16;
        route_q[p]      <= ZERO32;
        arrive_q[p]     <= '0;
        setup_seen_q[p] <= 1'b0;
      end else if (ce_in && sel) begin
        tag_q[p]        <= msg_q.tag;
        route_q[p]      <= msg_q.reply_route;
        arrive_q[p]     <= msg_q.via_port;
        setup_seen_q[p] <= 1'b1;
      end
    end

    // operational state and wrap exit
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        port_operational_out[p] <= 1'b0;
        begin_comm_out[p]       <= 1'b0;
      end else if (ce_in) begin
        begin_comm_out[p] <= sel && msg_q.mode == MODE_PRIV && port_cfg_out[p].mode == MODE_WRAP;
        if (sel && msg_q.mode == MODE_WRAP) begin
          port_operational_out[p] <= 1'b0;
        end else if (port_ready_in[p] && port_cfg_out[p].mode != MODE_WRAP) begin
          port_operational_out[p] <= 1'b1;
        end
      end
    end

    // recovery count and alarm threshold
    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        erp_cnt_q[p] <= ZERO16;
      end else if (ce_in) begin
        if (inquiry_clear_in[p]) begin
          erp_cnt_q[p] <= ZERO16;
        end else if (erp_invoked_in[p] && erp_cnt_q[p] != ERP_CNT_MAX) begin
          erp_cnt_q[p] <= erp_cnt_q[p] + 16'h0001;
        end
      end
    end

    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        alarm_pend_q[p] <= 1'b0;
      end else if (ce_in) begin
        if (erp_hit) begin
          alarm_pend_q[p] <= 1'b1;
        end else if (gnt_alarm[p]) begin
          alarm_pend_q[p] <= 1'b0;
        end
      end
    end

    always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
        slow_pend_q[p] <= 1'b0;
      end else if (ce_in) begin
        if (state_q == ST_SLOW && port_hit(msg_q.port, p) && dual_rate_cap_in[p] && running_slow_in[p]) begin
          slow_pend_q[p] <= 1'b1;
        end else if (gnt_slow[p]) begin
          slow_pend_q[p] <= 1'b0;
        end
      end
    end
  end

endmodule

// [bench/pcm_master_model.sv]
// master node model: offers setup messages, collects replies and alerts
`timescale 1ns/100ps
module pcm_master_model
  import pcm_pkg::*;
(
  input  wire logic           clk_in,
  input  wire logic           rst_in,
  input  wire logic           go_in,
  input  wire pcm_setup_msg_s req_in,
  input  wire logic           ready_in,
  input  wire pcm_reply_s     reply_in,
  input  wire pcm_alert_s     alert_in,
  output      logic           valid_out,
  output      pcm_setup_msg_s msg_out,
  output      logic           tag_busy_out,
  output      pcm_reply_s     reply_out,
  output      pcm_alert_s     alert_out,
  output      logic [7:0]     reply_cnt_out,
  output      logic [7:0]     alert_cnt_out
);
  pcm_setup_msg_s held_q;
  // released lines show the inverse of the last message
  assign msg_out = valid_out ? held_q : pcm_setup_msg_s'(~held_q);
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      valid_out <= 1'b0;
      held_q    <= '0;
    end else if (go_in) begin
      valid_out <= 1'b1;
      held_q    <= req_in;
    end else if (ready_in) begin
      valid_out <= 1'b0;
    end
  end
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tag_busy_out  <= 1'b0;
      reply_cnt_out <= 8'h00;
      alert_cnt_out <= 8'h00;
    end else begin
      if (valid_out && ready_in) begin
        tag_busy_out <= 1'b1;
      end else if (reply_in.valid) begin
        tag_busy_out <= 1'b0;
      end
      if (reply_in.valid) begin
        reply_out     <= reply_in;
        reply_cnt_out <= reply_cnt_out + 8'h01;
      end
      if (alert_in.valid) begin
        alert_out     <= alert_in;
        alert_cnt_out <= alert_cnt_out + 8'h01;
      end
    end
  end
endmodule

// [bench/pcm_port_setup_assertions.sv]
// checker of the port setup handler ports
`timescale 1ns/100ps
module pcm_port_setup_assertions
  import pcm_pkg::*;
(
  input wire logic                 sys_clk_in,
  input wire logic                 rst_in,
  input wire logic                 ce_in,
  input wire logic                 msg_valid_in,
  input wire pcm_setup_msg_s       msg_in,
  input wire logic                 msg_ready_out,
  input wire logic                 dual_port_node_in,
  input wire logic [NUM_PORTS-1:0] alert_pending_in,
  input wire logic [NUM_PORTS-1:0] flush_req_out,
  input wire logic [NUM_PORTS-1:0] port_operational_out,
  input wire logic [NUM_PORTS-1:0] begin_comm_out,
  input wire logic                 passthrough_flag_out,
  input wire pcm_port_cfg_s        port_cfg_out [NUM_PORTS],
  input wire pcm_reply_s           reply_out,
  input wire pcm_alert_s           alert_out
);
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  logic           take;
  pcm_setup_msg_s held_q;
  logic [15:0]    tag0_q;
  assign take = msg_valid_in && msg_ready_out && ce_in;
  always_ff @(posedge sys_clk_in) begin
    if (take) begin
      held_q <= msg_in;
    end
  end
  always_ff @(posedge sys_clk_in) begin
    if (reply_out.valid && reply_out.code == RC_OK && held_q.port == 8'h00) begin
      tag0_q <= held_q.tag;
    end
  end
  property p_reply_pulse; reply_out.valid |=> !reply_out.valid; endproperty
  a_reply_pulse: assert property (p_reply_pulse) else $error("reply valid too long");
  property p_reply_due; take && !(|alert_pending_in) |-> ##3 reply_out.valid; endproperty
  a_reply_due: assert property (p_reply_due) else $error("reply late");
  property p_route;
    reply_out.valid |-> reply_out.tag == held_q.tag && reply_out.route == held_q.reply_route
      && reply_out.out_port == held_q.via_port;
  endproperty
  a_route: assert property (p_route) else $error("reply address wrong");
  property p_bad_cap;
    take && msg_in.rotation_frame_cap < msg_in.first_frame_allowance && msg_in.mode != MODE_KEEP
      |-> ##3 reply_out.valid && reply_out.code == RC_BAD_FIELD;
  endproperty
  a_bad_cap: assert property (p_bad_cap) else $error("cap below allowance accepted");
  property p_wrap_same;
    take && msg_in.mode == MODE_WRAP && msg_in.port == 8'h00 && msg_in.via_port == 1'b0
      |-> ##3 reply_out.valid && reply_out.code == RC_BAD_FIELD;
  endproperty
  a_wrap_same: assert property (p_wrap_same) else $error("wrap via same port accepted");
  property p_wrap_off; port_cfg_out[0].mode == MODE_WRAP |-> !port_operational_out[0]; endproperty
  a_wrap_off: assert property (p_wrap_off) else $error("wrapped port operational");
  property p_short; !port_cfg_out[0].long_reach_on |-> port_cfg_out[0].ack_tmo_cycles == ACK_SHORT_CYC; endproperty
  a_short: assert property (p_short) else $error("short timeout wrong");
  property p_no_reflect; !dual_port_node_in |=> $stable(passthrough_flag_out); endproperty
  a_no_reflect: assert property (p_no_reflect) else $error("passthrough moved on single port");
  property p_flush_first; flush_req_out[0] |-> !reply_out.valid; endproperty
  a_flush_first: assert property (p_flush_first) else $error("reply before alerts flushed");
  property p_alert_tag; alert_out.valid && alert_out.port == 1'b0 |-> alert_out.tag == tag0_q; endproperty
  a_alert_tag: assert property (p_alert_tag) else $error("alert tag wrong");
  c_bad: cover property (reply_out.valid && reply_out.code == RC_BAD_FIELD);
  c_alert: cover property (alert_out.valid);
  c_begin: cover property (begin_comm_out[0]);
endmodule
bind pcm_port_setup pcm_port_setup_assertions u_chk (
  .sys_clk_in, .rst_in, .ce_in, .msg_valid_in, .msg_in, .msg_ready_out, .dual_port_node_in,
  .alert_pending_in, .flush_req_out, .port_operational_out, .begin_comm_out, .passthrough_flag_out,
  .port_cfg_out, .reply_out, .alert_out
);

// [bench/pcm_port_setup_tb.sv]
// self-checking bench of the port setup handler
`timescale 1ns/100ps
module pcm_port_setup_tb
  import pcm_pkg::*;
;
  logic sys_clk_in, rst_in, ce_in, msg_valid_in, msg_ready_out, dual_port_node_in, passthrough_flag_out;
  logic go, busy, via0, began;
  logic [1:0] long_reach_cap_in, dual_rate_cap_in, running_slow_in, alert_pending_in, erp_invoked_in;
  logic [1:0] inquiry_clear_in, port_ready_in, flush_req_out, port_operational_out, begin_comm_out;
  pcm_setup_msg_s msg_in, req;
  pcm_port_cfg_s port_cfg_out [NUM_PORTS];
  pcm_reply_s reply_out, lrep;
  pcm_alert_s alert_out, lalr;
  logic [7:0] rcnt, acnt, a0;
  logic [15:0] tag_n, tag0;
  int num_errors, checked;
  pcm_port_setup dut (.sys_clk_in, .rst_in, .ce_in, .msg_valid_in, .msg_in, .msg_ready_out,
    .dual_port_node_in, .long_reach_cap_in, .dual_rate_cap_in, .running_slow_in, .alert_pending_in,
    .erp_invoked_in, .inquiry_clear_in, .port_ready_in, .flush_req_out, .port_operational_out,
    .begin_comm_out, .passthrough_flag_out, .port_cfg_out, .reply_out, .alert_out);
  pcm_master_model master (.clk_in(sys_clk_in), .rst_in(rst_in), .go_in(go), .req_in(req),
    .ready_in(msg_ready_out), .reply_in(reply_out), .alert_in(alert_out), .valid_out(msg_valid_in),
    .msg_out(msg_in), .tag_busy_out(busy), .reply_out(lrep), .alert_out(lalr),
    .reply_cnt_out(rcnt), .alert_cnt_out(acnt));
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in) begin
    if (rst_in) began <= 1'b0;
    else if (begin_comm_out[0] === 1'b1) began <= 1'b1;
  end
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  function automatic pcm_setup_msg_s mk(input logic [7:0] p, input logic v, input logic [1:0] md,
                                        input logic [7:0] a, input logic [7:0] b);
    return '{port: p, via_port: v, mode: md, first_frame_allowance: a, rotation_frame_cap: b, default: '0};
  endfunction
  task automatic cfg(input pcm_setup_msg_s m, input logic [7:0] ex);
    logic [7:0] c;
    int n;
    c = rcnt;
    n = 0;
    tag_n = tag_n + 16'h0001;
    m.tag = tag_n;
    m.reply_route = {16'hc0de, tag_n};
    @(posedge sys_clk_in);
    req <= m;
    go <= 1'b1;
    @(posedge sys_clk_in);
    go <= 1'b0;
    while (rcnt === c && n < 40) begin
      @(negedge sys_clk_in);
      n++;
    end
    chk(rcnt, c + 8'h01);
    chk(lrep.code, ex);
    chk({lrep.tag, lrep.route, lrep.out_port}, {m.tag, m.reply_route, m.via_port});
    chk(busy, 1'b0);
    if (ex === RC_OK && m.port == 8'h00) begin
      tag0 = m.tag;
      via0 = m.via_port;
    end
  endtask
  task automatic alr_chk(input logic [7:0] c, input logic [23:0] code);
    repeat (12) @(negedge sys_clk_in);
    chk(acnt, c);
    chk(lalr.code, code);
    chk({lalr.tag, lalr.route, lalr.out_port}, {tag0, 16'hc0de, tag0, via0});
  endtask
  task automatic link_error_recovery(input int k);
    repeat (k) begin
      @(posedge sys_clk_in);
      erp_invoked_in <= 2'b01;
      @(posedge sys_clk_in);
      erp_invoked_in <= 2'b00;
    end
  endtask
  task automatic ready(input logic [1:0] p);
    @(posedge sys_clk_in);
    port_ready_in <= p;
    @(posedge sys_clk_in);
    port_ready_in <= 2'b00;
    @(negedge sys_clk_in);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    pcm_setup_msg_s m;
    logic [7:0] c;
    {rst_in, ce_in, dual_port_node_in, long_reach_cap_in} = 5'b11101;
    {go, dual_rate_cap_in, running_slow_in, alert_pending_in} = '0;
    {erp_invoked_in, inquiry_clear_in, port_ready_in, tag_n, num_errors, checked} = '0;
    req = '0;
    repeat (20) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    m = mk(8'h00, 1'b1, MODE_NORMAL, 8'h03, 8'h05);
    m.user_char_enable = 1'b1;
    cfg(m, RC_OK);
    chk({port_cfg_out[0].first_frame_allowance, port_cfg_out[0].rotation_frame_cap}, 16'h0305);
    chk(port_cfg_out[0].user_char_enable, 1'b1);
    cfg(mk(8'h00, 1'b1, MODE_NORMAL, 8'h02, 8'h02), RC_OK);
    chk({port_cfg_out[0].first_frame_allowance, port_cfg_out[0].user_char_enable}, 9'h004);
    cfg(mk(8'h00, 1'b1, MODE_NORMAL, 8'h04, 8'h03), RC_BAD_FIELD);
    chk(port_cfg_out[0].rotation_frame_cap, 8'h02);
    ready(2'b01);
    cfg(mk(8'h00, 1'b0, MODE_WRAP, 8'h01, 8'h01), RC_BAD_FIELD);
    chk({port_cfg_out[0].mode, port_operational_out[0]}, {MODE_NORMAL, 1'b1});
    cfg(mk(8'h00, 1'b1, MODE_WRAP, 8'h01, 8'h01), RC_OK);
    chk({port_cfg_out[0].mode, port_operational_out[0]}, {MODE_WRAP, 1'b0});
    m = mk(8'h01, 1'b0, MODE_NORMAL, 8'h01, 8'h01);
    m.reflect = 1'b1;
    cfg(m, RC_OK);
    chk(passthrough_flag_out, 1'b1);
    cfg(mk(8'h01, 1'b0, MODE_NORMAL, 8'h01, 8'h01), RC_OK);
    chk(passthrough_flag_out, 1'b1);
    cfg(mk(8'h00, 1'b1, MODE_NORMAL, 8'h01, 8'h01), RC_BAD_FIELD);
    ready(2'b01);
    chk({port_cfg_out[0].mode, port_operational_out[0]}, {MODE_WRAP, 1'b0});
    cfg(mk(8'h00, 1'b1, MODE_PRIV, 8'h01, 8'h01), RC_OK);
    chk({port_cfg_out[0].mode, began}, {MODE_PRIV, 1'b1});
    ready(2'b11);
    chk(port_operational_out, 2'b11);
    cfg(mk(8'h01, 1'b0, MODE_NORMAL, 8'h01, 8'h01), RC_OK);
    chk(passthrough_flag_out, 1'b0);
    @(posedge sys_clk_in);
    dual_port_node_in <= 1'b0;
    cfg(m, RC_OK);
    chk(passthrough_flag_out, 1'b0);
    m = mk(8'h01, 1'b0, MODE_NORMAL, 8'h01, 8'h01);
    m.long_reach_enable = 1'b1;
    cfg(m, RC_BAD_FIELD);
    m = mk(8'h00, 1'b1, MODE_NORMAL, 8'h01, 8'h01);
    m.long_reach_enable = 1'b1;
    cfg(m, RC_OK);
    chk({port_cfg_out[0].long_reach_on, port_cfg_out[0].ack_tmo_cycles}, {1'b1, ACK_LONG_CYC});
    m.short_ack_timeout = 1'b1;
    cfg(m, RC_OK);
    chk(port_cfg_out[0].ack_tmo_cycles, ACK_SHORT_CYC);
    cfg(mk(8'h00, 1'b1, MODE_NORMAL, 8'h01, 8'h01), RC_OK);
    chk({port_cfg_out[0].long_reach_on, port_cfg_out[0].ack_tmo_cycles}, {1'b0, ACK_SHORT_CYC});
    for (int i = 1; i < 5; i++) begin
      m = mk(8'h00, 1'b1, MODE_NORMAL, 8'h01, 8'h01);
      {m.offer_fast_rate, m.offer_slow_rate} = i[1:0];
      cfg(m, RC_OK);
      chk(port_cfg_out[0].offer_fast_rate, i[1] | (i == 4));
      chk(port_cfg_out[0].offer_slow_rate, i[0] | (i == 4));
      chk(port_cfg_out[0].single_speed, i[1] ^ i[0]);
    end
    m = mk(8'h00, 1'b1, MODE_NORMAL, 8'h01, 8'h01);
    m.alarm_threshold = 16'h0003;
    cfg(m, RC_OK);
    a0 = acnt;
    link_error_recovery(3);
    alr_chk(a0 + 8'h01, ALERT_ALARM_THR);
    link_error_recovery(2);
    alr_chk(a0 + 8'h01, ALERT_ALARM_THR);
    @(posedge sys_clk_in);
    inquiry_clear_in <= 2'b01;
    @(posedge sys_clk_in);
    inquiry_clear_in <= 2'b00;
    link_error_recovery(3);
    alr_chk(a0 + 8'h02, ALERT_ALARM_THR);
    @(posedge sys_clk_in);
    alert_pending_in <= 2'b01;
    c = rcnt;
    fork
      cfg(mk(8'h00, 1'b1, MODE_KEEP, 8'h01, 8'h01), RC_OK);
      begin
        repeat (8) @(negedge sys_clk_in);
        chk({flush_req_out[0], rcnt}, {1'b1, c});
        @(posedge sys_clk_in);
        alert_pending_in <= 2'b00;
      end
    join
    chk(port_cfg_out[0].mode, MODE_NORMAL);
    @(posedge sys_clk_in);
    {dual_rate_cap_in, running_slow_in} <= 4'b0101;
    cfg(mk(8'h00, 1'b1, MODE_NORMAL, 8'h01, 8'h01), RC_OK);
    alr_chk(a0 + 8'h03, ALERT_SLOW_SPEED);
    summarize();
  end
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    num_errors++;
    summarize();
  end
endmodule
